// ==== logic/ivs_defs.vh ====
// constants for the input voltage fault supervisor
`ifndef IVS_DEFS_VH
`define IVS_DEFS_VH

// command codes (register offsets)
`define IVS_CMD_OV_LIMIT 8'h55
`define IVS_CMD_OV_REACT 8'h56
`define IVS_CMD_UV_LIMIT 8'h59

// reaction byte fields
`define IVS_RESP_HI 7
`define IVS_RESP_LO 6
`define IVS_RETRY_HI 5
`define IVS_RETRY_LO 3
`define IVS_DELAY_HI 2
`define IVS_DELAY_LO 0
`define IVS_RESP_DISABLE 2'h2
`define IVS_RETRY_NONE 3'h0
`define IVS_RETRY_ALWAYS 3'h7

// linear format: 11-bit signed mantissa, 5-bit exponent on top
`define IVS_MANT_HI 10
`define IVS_EXP_LO 11
`define IVS_EXP_M3 5'h1D

// reset values: 60 V, 40 V at exponent -3, disable without retry
`define IVS_OV_LIMIT_RST 16'hE9E0
`define IVS_UV_LIMIT_RST 16'hE940
`define IVS_OV_REACT_RST 8'h80

// timing
`define IVS_CLK_PERIOD_NS 5
`define IVS_DELAY_UNIT_MS 200
`define IVS_DELAY_UNIT_CYC ((`IVS_DELAY_UNIT_MS * 1000000) / `IVS_CLK_PERIOD_NS)

// default bus address of the supervisor
`define IVS_BUS_ADDR 7'h40

`endif

// ==== logic/ivs_sync2.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ivs_sync2 #(
    parameter WIDTH = 2
) (
    input wire clock_i,
    input wire reset_n_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // idle bus level is high, so both stages reset high
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_r <= {WIDTH{1'b1}};
            sync_r <= {WIDTH{1'b1}};
        end
        else
        begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule

// ==== logic/ivs_retry_timer.v ====
// restart delay timer counted in whole delay units
`timescale 1ns/1ps
module ivs_retry_timer #(
    parameter UNIT_CYCLES = 40000000
) (
    input wire clock_i,
    input wire reset_n_i,
    input wire start_i,
    input wire [2:0] units_i,
    output wire done_o
);
    localparam [31:0] LAST_CYC = UNIT_CYCLES - 1;

    reg [31:0] cyc_r;
    reg [2:0] left_r;
    reg busy_r;
    reg done_r;

    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cyc_r <= 32'h0;
            left_r <= 3'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else if (start_i)
        begin
            cyc_r <= 32'h0;
            left_r <= units_i;
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            if (busy_r)
            begin
                if (left_r == 3'h0)
                begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
                else if (cyc_r == LAST_CYC)
                begin
                    cyc_r <= 32'h0;
                    left_r <= left_r - 3'h1;
                end
                else
                begin
                    cyc_r <= cyc_r + 32'h1;
                end
            end
        end
    end

    assign done_o = done_r;
endmodule

// ==== logic/ivs_top.v ====
// input voltage fault supervisor with its bus command slave
`timescale 1ns/1ps
`include "ivs_defs.vh"

module ivs_top #(
    parameter [6:0] BUS_ADDR = `IVS_BUS_ADDR,
    parameter DELAY_UNIT_CYCLES = `IVS_DELAY_UNIT_CYC
) (
    input wire clock_i,
    input wire reset_n_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    input wire [15:0] vin_meas_i,
    input wire vin_valid_i,
    input wire on_cmd_i,
    input wire bias_ok_i,
    input wire other_fault_i,
    input wire power_good_i,
    input wire clear_faults_i,
    output wire output_enable_o,
    output wire vin_ov_flag_o,
    output wire vin_uv_flag_o,
    output wire fault_latched_o
);
    localparam [3:0] P_IDLE = 4'h0;
    localparam [3:0] P_ADDR = 4'h1;
    localparam [3:0] P_AACK = 4'h2;
    localparam [3:0] P_CMD = 4'h3;
    localparam [3:0] P_WR = 4'h4;
    localparam [3:0] P_WACK = 4'h5;
    localparam [3:0] P_RD = 4'h6;
    localparam [3:0] P_RACK = 4'h7;
    localparam [3:0] P_RLD = 4'h8;

    localparam [2:0] F_OFF = 3'h0;
    localparam [2:0] F_RUN = 3'h1;
    localparam [2:0] F_WAIT = 3'h2;
    localparam [2:0] F_TRY = 3'h3;
    localparam [2:0] F_HOLD = 3'h4;

    // bytes a command carries; zero marks an unknown command
    function [1:0] cmd_bytes;
        input [7:0] cmd;
        begin
            case (cmd)
                `IVS_CMD_OV_LIMIT: cmd_bytes = 2'h2;
                `IVS_CMD_UV_LIMIT: cmd_bytes = 2'h2;
                `IVS_CMD_OV_REACT: cmd_bytes = 2'h1;
                default: cmd_bytes = 2'h0;
            endcase
        end
    endfunction

    // low byte first; bytes past the register read as all ones
    function [7:0] pick_byte;
        input [15:0] word;
        input [1:0] idx;
        input [1:0] nbytes;
        begin
            if (idx >= nbytes)
                pick_byte = 8'hFF;
            else if (idx == 2'h0)
                pick_byte = word[7:0];
            else
                pick_byte = word[15:8];
        end
    endfunction

    // strict signed compare of the mantissas, both at exponent -3
    function above;
        input [15:0] a;
        input [15:0] b;
        begin
            above = $signed(a[`IVS_MANT_HI:0]) > $signed(b[`IVS_MANT_HI:0]);
        end
    endfunction

    wire [1:0] pins_s;
    reg scl_d_r;
    reg sda_d_r;

    ivs_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .async_i({scl_i, sda_i}),
        .sync_o(pins_s)
    );

    wire scl_s = pins_s[1];
    wire sda_s = pins_s[0];
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

    reg [15:0] ov_limit_r;
    reg [15:0] uv_limit_r;
    reg [7:0] ov_react_r;
    reg [3:0] ps_r;
    reg [7:0] shift_r;
    reg [2:0] bit_cnt_r;
    reg [7:0] cmd_r;
    reg [1:0] idx_r;
    reg [7:0] wbuf_r;
    reg rw_r;
    reg ack_ok_r;
    reg ack_ph_r;
    reg sda_oe_r;

    wire [7:0] byte_in = {shift_r[6:0], sda_s};
    reg [15:0] sel_word;

    always @*
    begin
        case (cmd_r)
            `IVS_CMD_OV_LIMIT: sel_word = ov_limit_r;
            `IVS_CMD_UV_LIMIT: sel_word = uv_limit_r;
            `IVS_CMD_OV_REACT: sel_word = {8'h00, ov_react_r};
            default: sel_word = 16'hFFFF;
        endcase
    end

    wire [7:0] rd_byte = pick_byte(sel_word, idx_r, cmd_bytes(cmd_r));

    // bus slave: bits sampled on the rising clock edge, driven after the falling one
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            ov_limit_r <= `IVS_OV_LIMIT_RST;
            uv_limit_r <= `IVS_UV_LIMIT_RST;
            ov_react_r <= `IVS_OV_REACT_RST;
            ps_r <= P_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            cmd_r <= 8'h00;
            idx_r <= 2'h0;
            wbuf_r <= 8'h00;
            rw_r <= 1'b0;
            ack_ok_r <= 1'b0;
            ack_ph_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            if (bus_start)
            begin
                ps_r <= P_ADDR;
                bit_cnt_r <= 3'h0;
                idx_r <= 2'h0;
                ack_ph_r <= 1'b0;
                sda_oe_r <= 1'b0;
            end
            else if (bus_stop)
            begin
                ps_r <= P_IDLE;
                sda_oe_r <= 1'b0;
            end
            else
            begin
                case (ps_r)
                    P_ADDR, P_CMD, P_WR:
                    begin
                        if (scl_rise)
                        begin
                            shift_r <= byte_in;
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == 3'h7)
                            begin
                                ack_ph_r <= 1'b0;
                                if (ps_r == P_ADDR)
                                begin
                                    ack_ok_r <= (byte_in[7:1] == BUS_ADDR);
                                    rw_r <= byte_in[0];
                                    ps_r <= P_AACK;
                                end
                                else if (ps_r == P_CMD)
                                begin
                                    cmd_r <= byte_in;
                                    idx_r <= 2'h0;
                                    ack_ok_r <= (cmd_bytes(byte_in) != 2'h0);
                                    ps_r <= P_WACK;
                                end
                                else
                                begin
                                    ack_ok_r <= (idx_r < cmd_bytes(cmd_r));
                                    if (idx_r == 2'h0)
                                        wbuf_r <= byte_in;
                                    if (idx_r != 2'h3)
                                        idx_r <= idx_r + 2'h1;
                                    // limit words committed together on their high byte; the reaction byte at once
                                    if (cmd_r == `IVS_CMD_OV_REACT && idx_r == 2'h0)
                                        ov_react_r <= byte_in;
                                    if (cmd_r == `IVS_CMD_OV_LIMIT && idx_r == 2'h1)
                                        ov_limit_r <= {byte_in, wbuf_r};
                                    if (cmd_r == `IVS_CMD_UV_LIMIT && idx_r == 2'h1)
                                        uv_limit_r <= {byte_in, wbuf_r};
                                    ps_r <= P_WACK;
                                end
                            end
                        end
                    end
                    P_AACK, P_WACK:
                    begin
                        if (scl_fall)
                        begin
                            if (!ack_ph_r)
                            begin
                                ack_ph_r <= 1'b1;
                                sda_oe_r <= ack_ok_r;
                            end
                            else
                            begin
                                ack_ph_r <= 1'b0;
                                bit_cnt_r <= 3'h0;
                                if (!ack_ok_r)
                                begin
                                    sda_oe_r <= 1'b0;
                                    ps_r <= P_IDLE;
                                end
                                else if (ps_r == P_AACK && rw_r)
                                begin
                                    sda_oe_r <= ~rd_byte[7];
                                    shift_r <= {rd_byte[6:0], 1'b0};
                                    ps_r <= P_RD;
                                end
                                else
                                begin
                                    sda_oe_r <= 1'b0;
                                    ps_r <= (ps_r == P_AACK) ? P_CMD : P_WR;
                                end
                            end
                        end
                    end
                    P_RD:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe_r <= ~shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                        end
                        else if (scl_rise)
                        begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == 3'h7)
                            begin
                                ack_ph_r <= 1'b0;
                                ps_r <= P_RACK;
                            end
                        end
                    end
                    P_RACK:
                    begin
                        if (scl_fall && !ack_ph_r)
                        begin
                            sda_oe_r <= 1'b0;
                            ack_ph_r <= 1'b1;
                        end
                        else if (scl_rise && ack_ph_r)
                        begin
                            ack_ph_r <= 1'b0;
                            if (!sda_s)
                            begin
                                if (idx_r != 2'h3)
                                    idx_r <= idx_r + 2'h1;
                                ps_r <= P_RLD;
                            end
                            else
                            begin
                                ps_r <= P_IDLE;
                            end
                        end
                    end
                    P_RLD:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe_r <= ~rd_byte[7];
                            shift_r <= {rd_byte[6:0], 1'b0};
                            bit_cnt_r <= 3'h0;
                            ps_r <= P_RD;
                        end
                    end
                    default:
                    begin
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // fault supervision
    reg [2:0] fs_r;
    reg [2:0] fs_nxt;
    reg [2:0] tries_r;
    reg [2:0] tries_nxt;
    reg out_en_r;
    reg ov_flag_r;
    reg uv_flag_r;
    reg latched_r;
    reg tmr_start;
    wire tmr_done;

    wire [1:0] resp = ov_react_r[`IVS_RESP_HI:`IVS_RESP_LO];
    wire [2:0] retries = ov_react_r[`IVS_RETRY_HI:`IVS_RETRY_LO];
    wire [2:0] delay_units = ov_react_r[`IVS_DELAY_HI:`IVS_DELAY_LO];
    wire ov_trip = out_en_r & vin_valid_i & above(vin_meas_i, ov_limit_r);
    wire uv_trip = out_en_r & vin_valid_i & above(uv_limit_r, vin_meas_i);
    wire stop_req = ~on_cmd_i | ~bias_ok_i | other_fault_i;

    ivs_retry_timer #(
        .UNIT_CYCLES(DELAY_UNIT_CYCLES)
    ) u_timer (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .start_i(tmr_start),
        .units_i(delay_units),
        .done_o(tmr_done)
    );

    always @*
    begin
        fs_nxt = fs_r;
        tries_nxt = tries_r;
        tmr_start = 1'b0;
        case (fs_r)
            F_OFF:
            begin
                tries_nxt = 3'h0;
                if (!stop_req)
                    fs_nxt = F_RUN;
            end
            F_RUN, F_TRY, F_WAIT:
            begin
                if (stop_req)
                begin
                    fs_nxt = F_OFF;
                    tries_nxt = 3'h0;
                end
                else if (fs_r == F_WAIT)
                begin
                    if (tmr_done)
                    begin
                        fs_nxt = F_TRY;
                        if (retries != `IVS_RETRY_ALWAYS)
                            tries_nxt = tries_r + 3'h1;
                    end
                end
                else if (ov_trip && resp == `IVS_RESP_DISABLE)
                begin
                    if (retries == `IVS_RETRY_NONE)
                        fs_nxt = F_HOLD;
                    else if (retries == `IVS_RETRY_ALWAYS || tries_r < retries)
                    begin
                        fs_nxt = F_WAIT;
                        tmr_start = 1'b1;
                    end
                    else
                        fs_nxt = F_HOLD;
                end
                else if (fs_r == F_TRY && power_good_i)
                begin
                    fs_nxt = F_RUN;
                    tries_nxt = 3'h0;
                end
            end
            F_HOLD:
            begin
                if (clear_faults_i)
                begin
                    fs_nxt = F_OFF;
                    tries_nxt = 3'h0;
                end
            end
            default:
            begin
                fs_nxt = F_OFF;
                tries_nxt = 3'h0;
            end
        endcase
    end

    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fs_r <= F_OFF;
            tries_r <= 3'h0;
            out_en_r <= 1'b0;
            ov_flag_r <= 1'b0;
            uv_flag_r <= 1'b0;
            latched_r <= 1'b0;
        end
        else
        begin
            fs_r <= fs_nxt;
            tries_r <= tries_nxt;
            out_en_r <= (fs_nxt == F_RUN) || (fs_nxt == F_TRY);
            latched_r <= (fs_nxt == F_HOLD);
            // a trip in the clearing cycle keeps its flag
            ov_flag_r <= ov_trip | (ov_flag_r & ~clear_faults_i);
            uv_flag_r <= uv_trip | (uv_flag_r & ~clear_faults_i);
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_r;
    assign output_enable_o = out_en_r;
    assign vin_ov_flag_o = ov_flag_r;
    assign vin_uv_flag_o = uv_flag_r;
    assign fault_latched_o = latched_r;
endmodule

// ==== testbench/ivs_top_props.sv ====
// assertions on the supervisor's fault and output pins
`timescale 1ns/1ps
module ivs_top_props (
    input wire clock_i,
    input wire reset_n_i,
    input wire on_cmd_i,
    input wire bias_ok_i,
    input wire other_fault_i,
    input wire clear_faults_i,
    input wire output_enable_o,
    input wire vin_ov_flag_o,
    input wire vin_uv_flag_o,
    input wire fault_latched_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence s_stop;
        !on_cmd_i || !bias_ok_i || other_fault_i;
    endsequence
    sequence s_clear_held;
        fault_latched_o && clear_faults_i;
    endsequence
    ov_detect_a: assert property ($rose(vin_ov_flag_o) |-> $past(output_enable_o))
        else $error("ov flag set while output off");
    flag_clear_a: assert property (
        clear_faults_i && !output_enable_o |=> !vin_ov_flag_o && !vin_uv_flag_o)
        else $error("flags survived a clear");
    latch_hold_a: assert property (
        fault_latched_o && !clear_faults_i |=> fault_latched_o)
        else $error("latch dropped without clear");
    latch_off_a: assert property (fault_latched_o |-> !output_enable_o)
        else $error("output on while latched");
    latch_cause_a: assert property ($rose(fault_latched_o) |-> vin_ov_flag_o)
        else $error("latched without ov flag");
    latch_clear_a: assert property (s_clear_held |=> !fault_latched_o)
        else $error("clear did not release latch");
    start_cond_a: assert property (
        $rose(output_enable_o) |-> $past(on_cmd_i && bias_ok_i && !other_fault_i))
        else $error("output started without run request");
    stop_off_a: assert property (output_enable_o ##0 s_stop |-> ##[1:2] !output_enable_o)
        else $error("output kept on after stop");
endmodule

bind ivs_top ivs_top_props i_ivs_top_props (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .on_cmd_i(on_cmd_i),
    .bias_ok_i(bias_ok_i), .other_fault_i(other_fault_i), .clear_faults_i(clear_faults_i),
    .output_enable_o(output_enable_o), .vin_ov_flag_o(vin_ov_flag_o),
    .vin_uv_flag_o(vin_uv_flag_o), .fault_latched_o(fault_latched_o)
);

// ==== testbench/ivs_host_model.sv ====
// bus host model driving the command pins bit by bit
`timescale 1ns/1ps
module ivs_host_model (
    input wire sda_oe_i,
    output logic scl_o,
    output wire sda_o
);
    localparam int Q = 16;
    logic low_r = 1'b0;
    logic nack_seen = 1'b0;
    initial scl_o = 1'b1;
    // pulled-up wire, low while either side pulls
    assign sda_o = ~(low_r | sda_oe_i);
    task automatic bitx(input logic b, output logic r);
        #Q low_r = ~b;
        #Q scl_o = 1'b1;
        #Q r = sda_o;
        #Q scl_o = 1'b0;
    endtask
    task automatic start();
        #Q low_r = 1'b0;
        #Q scl_o = 1'b1;
        #Q low_r = 1'b1;
        #Q scl_o = 1'b0;
    endtask
    task automatic stop();
        #Q low_r = 1'b1;
        #Q scl_o = 1'b1;
        #Q low_r = 1'b0;
        #Q;
    endtask
    task automatic xbyte(input logic [7:0] tx, input logic m, output logic [7:0] rx);
        logic a;
        for (int i = 7; i >= 0; i--)
            bitx(tx[i], rx[i]);
        bitx(m, a);
        // acknowledge slot left high is a refusal
        if (m && a)
            nack_seen = 1'b1;
    endtask
    // address 0x40; words go low byte first
    task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int nb);
        logic [7:0] rx;
        nack_seen = 1'b0;
        start();
        xbyte(8'h80, 1'b1, rx);
        xbyte(cmd, 1'b1, rx);
        xbyte(d[7:0], 1'b1, rx);
        if (nb == 2)
            xbyte(d[15:8], 1'b1, rx);
        stop();
    endtask
    task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
        logic [7:0] rx;
        start();
        xbyte(8'h80, 1'b1, rx);
        xbyte(cmd, 1'b1, rx);
        start();
        xbyte(8'h81, 1'b1, rx);
        xbyte(8'hFF, 1'b0, d[7:0]);
        xbyte(8'hFF, 1'b1, d[15:8]);
        stop();
    endtask
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the input voltage fault supervisor
`timescale 1ns/1ps
module tb;
    localparam int DU = 8;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [15:0] vin_meas_i = 16'hE9B0;
    logic vin_valid_i = 1'b1;
    logic on_cmd_i = 1'b1;
    logic bias_ok_i = 1'b1;
    logic other_fault_i = 1'b0;
    logic power_good_i = 1'b0;
    logic clear_faults_i = 1'b0;
    int num_errors = 0;
    int samples_checked = 0;
    wire scl, sda, sda_o, sda_oe_o, output_enable_o;
    wire vin_ov_flag_o, vin_uv_flag_o, fault_latched_o;
    initial forever #2.5 clock_i = ~clock_i;
    ivs_top #(
        .DELAY_UNIT_CYCLES(DU)
    ) i_ivs_top (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .vin_meas_i(vin_meas_i),
        .vin_valid_i(vin_valid_i), .on_cmd_i(on_cmd_i), .bias_ok_i(bias_ok_i),
        .other_fault_i(other_fault_i), .power_good_i(power_good_i),
        .clear_faults_i(clear_faults_i), .output_enable_o(output_enable_o),
        .vin_ov_flag_o(vin_ov_flag_o), .vin_uv_flag_o(vin_uv_flag_o),
        .fault_latched_o(fault_latched_o)
    );
    ivs_host_model i_host (
        .sda_oe_i(sda_oe_o), .scl_o(scl), .sda_o(sda)
    );
    // linear value with exponent -3
    function automatic logic [15:0] lin(input logic [10:0] m);
        return {5'h1D, m};
    endfunction
    task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chkb(input string w, input logic e, input logic g);
        check(w, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic finish_test();
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic set_vin(input logic [15:0] v);
        @(posedge clock_i);
        vin_meas_i <= v;
    endtask
    task automatic clr();
        @(posedge clock_i);
        clear_faults_i <= 1'b1;
        @(posedge clock_i);
        clear_faults_i <= 1'b0;
    endtask
    task automatic react(input logic [7:0] b);
        i_host.wr(8'h56, {8'h00, b}, 1);
    endtask
    task automatic wait_oe(input logic v);
        int n;
        #1;
        n = 0;
        while (output_enable_o !== v && n < 100)
        begin
            cyc(1);
            n++;
        end
        chkb("output wait", v, output_enable_o);
        if (output_enable_o !== v)
            finish_test();
    endtask
    // counts output restarts and the shortest off stretch before one
    task automatic watch(input int lim, output int rises, output int lowmin);
        int low;
        logic prev;
        rises = 0;
        low = 0;
        lowmin = 9999;
        #1;
        prev = output_enable_o;
        repeat (lim)
        begin
            cyc(1);
            if (output_enable_o === 1'b1 && prev === 1'b0)
            begin
                rises++;
                lowmin = (low < lowmin) ? low : lowmin;
            end
            low = (output_enable_o === 1'b1) ? 0 : low + 1;
            prev = output_enable_o;
        end
    endtask
    task automatic t_regs();
        logic [15:0] d;
        i_host.rd(8'h55, d);
        check("ov limit reset", 16'hE9E0, d);
        i_host.rd(8'h56, d);
        check("reaction reset", 16'hFF80, d);
        i_host.rd(8'h59, d);
        check("uv limit reset", 16'hE940, d);
        i_host.wr(8'h55, lin(11'h1C0), 2);
        i_host.wr(8'h59, lin(11'h150), 2);
        react(8'h15);
        i_host.rd(8'h55, d);
        check("ov limit", 16'hE9C0, d);
        i_host.rd(8'h59, d);
        check("uv limit", 16'hE950, d);
        i_host.rd(8'h56, d);
        check("reaction", 16'hFF15, d);
        i_host.wr(8'h57, 16'h0000, 1);
        chkb("unknown cmd refused", 1'b1, i_host.nack_seen);
        chkb("sda value", 1'b0, sda_o);
    endtask
    task automatic t_thresh();
        for (int k = 0; k < 4; k++)
        begin
            if (k == 2)
                continue;
            react({k[1:0], 6'h00});
            set_vin(lin(11'h1C0));
            cyc(4);
            chkb("ov at limit", 1'b0, vin_ov_flag_o);
            set_vin(lin(11'h1C1));
            cyc(4);
            chkb("ov above", 1'b1, vin_ov_flag_o);
            chkb("ov ignored", 1'b1, output_enable_o);
            set_vin(lin(11'h1B0));
            clr();
        end
        set_vin(lin(11'h150));
        cyc(4);
        chkb("uv at limit", 1'b0, vin_uv_flag_o);
        set_vin(lin(11'h14F));
        cyc(4);
        chkb("uv below", 1'b1, vin_uv_flag_o);
        set_vin(lin(11'h1B0));
        clr();
        cyc(2);
        chkb("uv cleared", 1'b0, vin_uv_flag_o);
    endtask
    task automatic t_standby();
        react(8'h80);
        @(posedge clock_i);
        on_cmd_i <= 1'b0;
        clr();
        set_vin(lin(11'h1C1));
        cyc(8);
        chkb("flag in standby", 1'b0, vin_ov_flag_o);
        @(posedge clock_i);
        on_cmd_i <= 1'b1;
        cyc(8);
        chkb("flag after ramp", 1'b1, vin_ov_flag_o);
        chkb("latched off", 1'b1, fault_latched_o);
        set_vin(lin(11'h1B0));
        cyc(40);
        chkb("stays off", 1'b0, output_enable_o);
        clr();
        wait_oe(1'b1);
    endtask
    task automatic t_retry();
        int r;
        int lm;
        logic [2:0] d;
        for (int n = 1; n <= 6; n++)
        begin
            d = 3'(7 - n);
            set_vin(lin(11'h1B0));
            react({2'b10, n[2:0], d});
            clr();
            wait_oe(1'b1);
            set_vin(lin(11'h1C1));
            watch(400, r, lm);
            check("retries", 16'(n), 16'(r));
            chkb("latched after retries", 1'b1, fault_latched_o);
            chkb("retry spacing", 1'b1, lm >= d * DU && lm <= d * DU + 4);
        end
    endtask
    task automatic t_renew();
        int r;
        int lm;
        set_vin(lin(11'h1B0));
        react(8'h88);
        clr();
        wait_oe(1'b1);
        @(posedge clock_i);
        power_good_i <= 1'b1;
        repeat (3)
        begin
            set_vin(lin(11'h1C1));
            set_vin(lin(11'h1B0));
            watch(40, r, lm);
            check("restart per event", 16'h0001, 16'(r));
        end
        @(posedge clock_i);
        power_good_i <= 1'b0;
    endtask
    task automatic t_cont();
        int r;
        int lm;
        set_vin(lin(11'h1B0));
        react(8'hB9);
        clr();
        wait_oe(1'b1);
        set_vin(lin(11'h1C1));
        watch(200, r, lm);
        chkb("endless retries", 1'b1, r > 8);
        chkb("never latched", 1'b0, fault_latched_o);
        @(posedge clock_i);
        other_fault_i <= 1'b1;
        watch(30, r, lm);
        check("stopped", 16'h0000, 16'(r));
        chkb("off when stopped", 1'b0, output_enable_o);
    endtask
    initial
    begin
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'b1;
        cyc(4);
        chkb("on after reset", 1'b1, output_enable_o);
        t_regs();
        t_thresh();
        t_standby();
        t_retry();
        t_renew();
        t_cont();
        finish_test();
    end
endmodule
